/* bench/tb_top.sv */
// Self-checking bench for the supply, ground and clock fault monitor
`timescale 1ns/1ns
module tb_top;
  import fault_mon_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic                     ref_clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     cp_uv_raw = 1'b0;
  logic [REG_W-1:0]         reg_fault = 4'h0;
  logic [REG_W-1:0]         reg_cmp_resp = 4'h0;
  logic [1:0]               gnd_loss = 2'h0;
  logic [3:0]               ch_loss = 4'h0;
  logic                     ref_osc = 1'b0;
  logic                     main_osc_stuck = 1'b0;
  logic [2:0]               rd_pulse = 3'h0;
  logic [3:0]               rd_chan = 4'h0;
  logic                     on_demand_test_control_start = 1'b0;
  logic [3:0]               chan_test_start = 4'h0;
  logic [3:0]               sol_reenable = 4'h0;
  logic                     fs_reenable = 1'b0;
  logic [FLAG_W-1:0]        flags_a, flags_b, odt_ctl;
  logic [3:0][FLAG_W-1:0]   ch_flags;
  logic                     reg_test_inj, gnd_test_inj, fs_predrv_en, safety_off;
  logic [3:0]               sol_en;
  logic [3:0]               ch_inj;
  int                       ref_half = 5;
  int                       ref_cnt = 0;
  int                       cyc_cnt = 0;
  int                       miscompares = 0;
  int                       checked = 0;

  fault_monitor i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cp_uv_raw(cp_uv_raw),
    .reg_fault(reg_fault), .reg_cmp_resp(reg_cmp_resp), .analog_ground_loss(gnd_loss[0]),
    .digital_ground_loss(gnd_loss[1]), .channel_power_ground_loss(ch_loss),
    .ref_osc(ref_osc), .main_osc_stuck(main_osc_stuck), .rd_flags_a(rd_pulse[0]),
    .rd_flags_b(rd_pulse[1]), .rd_chan_flags(rd_chan), .on_demand_test_control_start(on_demand_test_control_start),
    .chan_test_start(chan_test_start), .sol_reenable(sol_reenable),
    .fs_reenable(fs_reenable), .supply_fault_flags_a(flags_a),
    .supply_selftest_flags_b(flags_b), .channel_fault_flags_b(ch_flags),
    .on_demand_test_control(odt_ctl), .reg_test_inj(reg_test_inj),
    .gnd_test_inj(gnd_test_inj), .chan_test_inj(ch_inj), .sol_en(sol_en),
    .fs_predrv_en(fs_predrv_en), .safety_off(safety_off));

  // ==========================================================
  // Clocks and watchdog
  always #50 ref_clk = ~ref_clk;
  // Half period in main cycles; zero freezes the reference
  always @(posedge ref_clk) begin
    if (ref_half != 0) begin
      if (ref_cnt >= ref_half - 1) begin
        ref_cnt <= 0;
        ref_osc <= ~ref_osc;
      end else begin
        ref_cnt <= ref_cnt + 1;
      end
    end
  end
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ==========================================================
  // Access tasks and compares
  task automatic run(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // Reads: 0 flags a, 1 flags b, 2 channel flags by mask
  task automatic rd(input int which, input logic [3:0] ch);
    @(posedge ref_clk);
    rd_pulse <= (which < 2) ? 3'(1 << which) : 3'h0;
    rd_chan  <= (which == 2) ? ch : 4'h0;
    @(posedge ref_clk);
    rd_pulse <= 3'h0;
    rd_chan  <= 4'h0;
    run(1);
  endtask
  task automatic reen();
    @(posedge ref_clk);
    sol_reenable <= 4'hf;
    fs_reenable  <= 1'b1;
    @(posedge ref_clk);
    sol_reenable <= 4'h0;
    fs_reenable  <= 1'b0;
    run(1);
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    run(10);
    chk_word(flags_a, 16'h0200);
    chk_flag(gnd_test_inj, 1'b1);
    chk_word({12'h000, sol_en}, 16'h0000);
    chk_flag(fs_predrv_en, 1'b0);
    rst_n <= 1'b1;
    // Grounds never shown lost during the start-up test, so both must fail
    run(40);
    chk_word({14'h0, flags_b[3:2]}, 16'h0003);
    chk_flag(gnd_test_inj, 1'b0);
    rd(1, 4'h0);
    rd(0, 4'h0);
    chk_word(flags_b & 16'h000c, 16'h0000);
    run(250);
    reen();
    chk_word({12'h000, sol_en}, 16'h000f);
    chk_flag(fs_predrv_en, 1'b1);
    // Charge pump: too short, then persisting, read while present, release
    cp_uv_raw <= 1'b1;
    run(80);
    chk_flag(flags_a[SFA_CP_UV], 1'b0);
    run(45);
    chk_flag(flags_a[SFA_CP_UV], 1'b1);
    chk_word({12'h000, sol_en, 3'h0, fs_predrv_en}, 16'h0000);
    rd(0, 4'h0);
    chk_flag(flags_a[SFA_CP_UV], 1'b1);
    cp_uv_raw <= 1'b0;
    run(130);
    rd(0, 4'h0);
    chk_flag(flags_a[SFA_CP_UV], 1'b0);
    chk_flag(fs_predrv_en, 1'b0);
    // Analog then digital ground loss
    for (int i = 0; i < 2; i++) begin
      reen();
      gnd_loss <= 2'(1 << i);
      run(230);
      chk_flag(flags_a[SFA_ANALOG_GROUND + i], 1'b1);
      chk_word({12'h000, sol_en, 3'h0, fs_predrv_en}, 16'h0000);
      gnd_loss <= 2'h0;
      run(230);
      rd(0, 4'h0);
      chk_flag(flags_a[SFA_ANALOG_GROUND + i], 1'b0);
    end
    reen();
    ch_loss <= 4'h1;
    run(510);
    chk_flag(ch_flags[0][CHB_GND_LOSS], 1'b1);
    chk_word({12'h000, sol_en}, 16'h000e);
    chk_flag(fs_predrv_en, 1'b1);
    ch_loss <= 4'h0;
    run(510);
    rd(2, 4'h1);
    chk_flag(ch_flags[0][CHB_GND_LOSS], 1'b0);
    reen();
    // Channel self-test with a comparator that never trips
    @(posedge ref_clk);
    chan_test_start <= 4'h4;
    @(posedge ref_clk);
    chan_test_start <= 4'h0;
    run(1);
    chk_flag(ch_flags[2][CHB_GND_BUSY], 1'b1);
    chk_flag(ch_inj[2], 1'b1);
    run(40);
    chk_flag(ch_flags[2][CHB_GND_BUSY], 1'b0);
    chk_flag(ch_flags[2][CHB_GND_LOSS], 1'b1);
    // Oscillators
    main_osc_stuck <= 1'b1;
    run(2);
    chk_word({14'h0, safety_off, fs_predrv_en}, 16'h0002);
    main_osc_stuck <= 1'b0;
    run(3);
    chk_word({14'h0, safety_off, fs_predrv_en}, 16'h0001);
    for (int h = 4; h <= 6; h += 2) begin
      ref_half <= h;
      run(400);
      chk_flag(safety_off, 1'b1);
      ref_half <= 5;
      run(400);
      chk_flag(safety_off, 1'b0);
    end
    ref_half <= 0;
    run(700);
    chk_flag(flags_b[SFB_REF_STUCK], 1'b1);
    chk_word({12'h000, sol_en}, 16'h000f);
    ref_half <= 5;
    run(400);
    // On-demand test that fails, then one that passes
    for (int p = 0; p < 2; p++) begin
      // A failed test restarts the start-up test, which must end first
      run(40);
      reg_cmp_resp <= p ? 4'hf : 4'h0;
      rd(1, 4'h0);
      rd(0, 4'h0);
      @(posedge ref_clk);
      on_demand_test_control_start <= 1'b1;
      @(posedge ref_clk);
      on_demand_test_control_start <= 1'b0;
      run(1);
      chk_flag(odt_ctl[ODT_RUN], 1'b1);
      chk_flag(reg_test_inj, 1'b1);
      run(40);
      chk_flag(odt_ctl[ODT_RUN], 1'b0);
      chk_flag(flags_a[SFA_POR], 1'(p == 0));
      chk_flag(flags_b[SFB_OD_FAIL], 1'(p == 0));
    end
    reg_fault <= 4'h4;
    run(2);
    reg_fault <= 4'h0;
    run(2);
    chk_flag(flags_a[SFA_POR], 1'b1);
    chk_word({12'h000, sol_en, 3'h0, fs_predrv_en}, 16'h0000);
    give_verdict();
  end
endmodule

/* rtl/deglitch_filter.sv */
// Persistence filter for comparator levels, one counter per bit
`timescale 1ns/1ns
module deglitch_filter #(
  parameter int CYC = 90
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  filt_if.flt      f
);

  localparam int W     = $bits(f.raw);
  localparam int CNT_W = $clog2(CYC + 1);

  if (CYC < 2) begin : g_chk
    $error("deglitch_filter: CYC must be at least 2");
  end

  logic [CNT_W-1:0] cnt_r [W];
  logic [W-1:0]     filt_r;

  // ==========================================================
  // Both edges must persist CYC cycles; glitches restart the count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < W; i++) begin
        cnt_r[i] <= '0;
      end
      filt_r <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (f.raw[i] == filt_r[i]) begin
          cnt_r[i] <= '0;
        end else if (cnt_r[i] == CNT_W'(CYC - 1)) begin
          cnt_r[i]  <= '0;
          filt_r[i] <= f.raw[i];
        end else begin
          cnt_r[i] <= cnt_r[i] + CNT_W'(1);
        end
      end
    end
  end

  assign f.filt = filt_r;

  filt_persist_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (filt_r[0] != $past(filt_r[0])) |-> ($past(cnt_r[0]) == CNT_W'(CYC - 1))
  ) else $error("filter output changed before the persistence count");

endmodule

/* rtl/fault_mon_pkg.sv */
// Constants, types and helpers shared by the supply, ground and clock fault monitor
package fault_mon_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int US_HZ           = 1_000_000;
  localparam int CP_UV_MIN_US    = 9;
  localparam int CP_UV_MAX_US    = 12;
  localparam int CP_UV_CYC       = (CP_UV_MIN_US * CLK_HZ + US_HZ - 1) / US_HZ;
  localparam int GND_LOST_MIN_US = 14;
  localparam int GND_LOST_CYC    = (GND_LOST_MIN_US * CLK_HZ + US_HZ - 1) / US_HZ;
  localparam int SOL_GND_MIN_US  = 35;
  localparam int SOL_GND_CYC     = (SOL_GND_MIN_US * CLK_HZ + US_HZ - 1) / US_HZ;
  localparam int OSC_TIMEOUT_US  = 60;
  localparam int OSC_TIMEOUT_CYC = OSC_TIMEOUT_US * CLK_HZ / US_HZ;
  localparam int FREQ_ERR_PCT    = 15;
  localparam int ST_WAIT_CYC     = 32;

  // ==========================================================
  // Flag registers
  localparam int FLAG_W = 16;
  localparam int REG_W  = 4;

  localparam int SFA_CP_UV  = 3;
  localparam int SFA_POR    = 9;
  localparam int SFA_ANALOG_GROUND   = 14;
  localparam int SFA_DIGITAL_GROUND   = 15;

  localparam int SFB_REF_STUCK = 0;
  localparam int SFB_MAIN_OSC  = 1;
  localparam int SFB_ANALOG_GROUND_ST   = 2;
  localparam int SFB_DIGITAL_GROUND_ST   = 3;
  localparam int SFB_OD_FAIL   = 5;

  localparam int CHB_GND_LOSS = 3;
  localparam int CHB_GND_BUSY = 5;

  localparam int ODT_RUN = 0;

  localparam logic [FLAG_W-1:0] SFA_RST = 16'h0200;
  localparam logic [FLAG_W-1:0] SFB_RST = 16'h0000;
  localparam logic [FLAG_W-1:0] CHB_RST = 16'h0000;

  // ==========================================================
  // Types and helpers
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PORTEST = 2'b01,
    ST_ON_DEMAND_TEST_CONTROL  = 2'b10
  } test_st_t;

  // Sticky flag: a set in the clearing cycle wins
  function automatic logic sticky(input logic flag, input logic clr, input logic set);
    return (flag & ~clr) | set;
  endfunction

endpackage

/* rtl/fault_monitor.sv */
// Supply, ground and oscillator fault monitor for a four-channel solenoid driver
// ==========================================================
// What this block does
// - Filtered charge-pump undervoltage flags and disables all drivers
// - Flag read clears; drivers stay off until re-enabled
// - Charge-pump undervoltage must persist nine to twelve microseconds
// - Regulator or bandgap fault causes power-on reset event
// - Reset event clears registers, disables outputs, sets reset flag
// - Self-test start bit reads one while testing
// - Failed on-demand self-test forces reset and sets flag
// - Analog and digital ground loss flagged continuously outside the start-up self-test
// - Ground comparators self-tested after every reset event
// - Analog or digital ground loss disables all drivers
// - Channel ground loss disables only that channel
// - Channel ground self-test start, busy bit while running
// - Channel ground test result shown in loss bit
// - Channel ground loss keeps fail-safe, clears on read
// - Main oscillator fault holds fail-safe off until recovery
// - Stuck reference oscillator only reported, operation continues
// - Clock declared stuck after sixty microseconds silence
// - Oscillator mismatch beyond fifteen percent is flagged
`timescale 1ns/1ns
module fault_monitor
  import fault_mon_pkg::*;
#(
  parameter int NCH     = 4,
  parameter int REF_HZ  = 1_000_000,
  parameter int REF_WIN = 16
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         cp_uv_raw,
  input  wire logic [REG_W-1:0]             reg_fault,
  input  wire logic [REG_W-1:0]             reg_cmp_resp,
  input  wire logic                         analog_ground_loss,
  input  wire logic                         digital_ground_loss,
  input  wire logic [NCH-1:0]               channel_power_ground_loss,
  input  wire logic                         ref_osc,
  input  wire logic                         main_osc_stuck,
  input  wire logic                         rd_flags_a,
  input  wire logic                         rd_flags_b,
  input  wire logic [NCH-1:0]               rd_chan_flags,
  input  wire logic                         on_demand_test_control_start,
  input  wire logic [NCH-1:0]               chan_test_start,
  input  wire logic [NCH-1:0]               sol_reenable,
  input  wire logic                         fs_reenable,
  output logic      [FLAG_W-1:0]            supply_fault_flags_a,
  output logic      [FLAG_W-1:0]            supply_selftest_flags_b,
  output logic      [NCH-1:0][FLAG_W-1:0]   channel_fault_flags_b,
  output logic      [FLAG_W-1:0]            on_demand_test_control,
  output logic                              reg_test_inj,
  output logic                              gnd_test_inj,
  output logic      [NCH-1:0]               chan_test_inj,
  output logic      [NCH-1:0]               sol_en,
  output logic                              fs_predrv_en,
  output logic                              safety_off
);

  localparam int NOM_CYC = CLK_HZ / REF_HZ * REF_WIN;
  localparam int HI_CYC  = NOM_CYC * (100 + FREQ_ERR_PCT) / 100;
  localparam int LO_CYC  = NOM_CYC * (100 - FREQ_ERR_PCT) / 100;
  localparam int PER_W   = 16;
  localparam int TO_W    = $clog2(OSC_TIMEOUT_CYC + 1);
  localparam int WIN_W   = $clog2(REF_WIN + 1);
  localparam int TC_W    = $clog2(ST_WAIT_CYC + 1);

  if (NCH < 1 || NCH > 8 || REF_HZ * 4 > CLK_HZ || REF_WIN < 1
      || HI_CYC >= 2 ** PER_W || ST_WAIT_CYC < 8) begin : g_chk
    $error("fault_monitor: unsupported parameter values");
  end

  // ==========================================================
  // Filters
  filt_if #(.W(1))   cp_if  ();
  filt_if #(.W(2))   gnd_if ();
  filt_if #(.W(NCH)) sol_if ();

  assign cp_if.raw  = cp_uv_raw;
  assign gnd_if.raw = {digital_ground_loss, analog_ground_loss};
  assign sol_if.raw = channel_power_ground_loss;

  deglitch_filter #(.CYC(CP_UV_CYC))    u_cp_filt  (.ref_clk(ref_clk), .rst_n(rst_n), .f(cp_if));
  deglitch_filter #(.CYC(GND_LOST_CYC)) u_gnd_filt (.ref_clk(ref_clk), .rst_n(rst_n), .f(gnd_if));
  deglitch_filter #(.CYC(SOL_GND_CYC))  u_sol_filt (.ref_clk(ref_clk), .rst_n(rst_n), .f(sol_if));

  // ==========================================================
  // Fault qualification
  test_st_t         st_r;
  test_st_t         st_nxt;
  logic [TC_W-1:0]  tcnt_r;
  logic [REG_W-1:0] seen_r;
  logic             od_fail;
  logic             por_req;
  logic             cp_uv_f;
  logic             analog_ground_f;
  logic             digital_ground_f;
  logic             global_off;
  logic [NCH-1:0]   chan_busy_r;
  logic [NCH-1:0]   chan_seen_r;
  logic [TC_W-1:0]  chan_cnt_r [NCH];
  logic [NCH-1:0]   chan_fail;
  logic [NCH-1:0]   chan_loss_f;
  logic             osc_fault;
  logic             ref_stuck;
  logic             mismatch_r;
  logic [NCH-1:0]   sol_en_r;
  logic [NCH-1:0]   sol_en_nxt;
  logic             fs_en_r;
  logic             fs_en_nxt;

  assign cp_uv_f    = cp_if.filt[0];
  // Injected ground stimulus must not look like a real loss
  assign analog_ground_f     = gnd_if.filt[0] && (st_r != ST_PORTEST);
  assign digital_ground_f     = gnd_if.filt[1] && (st_r != ST_PORTEST);
  assign global_off = cp_uv_f || analog_ground_f || digital_ground_f;
  assign chan_loss_f = sol_if.filt & ~chan_busy_r;
  assign por_req    = (|reg_fault) || od_fail;
  assign osc_fault  = main_osc_stuck || mismatch_r;

  // ==========================================================
  // Supply self-test sequencer
  always_comb begin
    st_nxt  = st_r;
    od_fail = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (on_demand_test_control_start) begin
          st_nxt = ST_ON_DEMAND_TEST_CONTROL;
        end
      end
      ST_PORTEST: begin
        if (tcnt_r == TC_W'(ST_WAIT_CYC - 1)) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_ON_DEMAND_TEST_CONTROL: begin
        if (tcnt_r == TC_W'(ST_WAIT_CYC - 1)) begin
          st_nxt  = ST_IDLE;
          od_fail = ~&(seen_r | reg_cmp_resp);
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= ST_PORTEST;
      tcnt_r <= '0;
      seen_r <= '0;
    end else if (por_req) begin
      st_r   <= ST_PORTEST;
      tcnt_r <= '0;
      seen_r <= '0;
    end else begin
      st_r   <= st_nxt;
      tcnt_r <= (st_nxt != st_r || st_r == ST_IDLE) ? '0 : tcnt_r + TC_W'(1);
      if (st_nxt != st_r) begin
        seen_r <= '0;
      end else if (st_r == ST_ON_DEMAND_TEST_CONTROL) begin
        seen_r <= seen_r | reg_cmp_resp;
      end else if (st_r == ST_PORTEST) begin
        seen_r <= seen_r | {2'b00, digital_ground_loss, analog_ground_loss};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_test_inj           <= 1'b0;
      gnd_test_inj           <= 1'b1;
      on_demand_test_control <= '0;
    end else begin
      reg_test_inj           <= !por_req && (st_nxt == ST_ON_DEMAND_TEST_CONTROL);
      gnd_test_inj           <= por_req || (st_nxt == ST_PORTEST);
      on_demand_test_control <= '0;
      on_demand_test_control[ODT_RUN] <= !por_req && (st_nxt == ST_ON_DEMAND_TEST_CONTROL);
    end
  end

  // ==========================================================
  // Channel ground-loss self-test
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      chan_fail[c] = chan_busy_r[c] && (chan_cnt_r[c] == TC_W'(ST_WAIT_CYC - 1))
                     && !(chan_seen_r[c] || channel_power_ground_loss[c]);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_busy_r <= '0;
      chan_seen_r <= '0;
      for (int c = 0; c < NCH; c++) begin
        chan_cnt_r[c] <= '0;
      end
    end else if (por_req) begin
      chan_busy_r <= '0;
      chan_seen_r <= '0;
      for (int c = 0; c < NCH; c++) begin
        chan_cnt_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (!chan_busy_r[c]) begin
          chan_busy_r[c] <= chan_test_start[c];
          chan_seen_r[c] <= 1'b0;
          chan_cnt_r[c]  <= '0;
        end else begin
          chan_seen_r[c] <= chan_seen_r[c] || channel_power_ground_loss[c];
          chan_cnt_r[c]  <= chan_cnt_r[c] + TC_W'(1);
          if (chan_cnt_r[c] == TC_W'(ST_WAIT_CYC - 1)) begin
            chan_busy_r[c] <= 1'b0;
          end
        end
      end
    end
  end

  // Injection follows the busy bit one cycle later
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_test_inj <= '0;
    end else begin
      chan_test_inj <= por_req ? '0 : chan_busy_r;
    end
  end

  // ==========================================================
  // Oscillator monitor
  logic               ref_d_r;
  logic               ref_edge;
  logic [TO_W-1:0]    since_r;
  logic [PER_W-1:0]   per_r;
  logic [WIN_W-1:0]   win_r;

  assign ref_edge  = ref_osc && !ref_d_r;
  assign ref_stuck = (since_r == TO_W'(OSC_TIMEOUT_CYC));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d_r <= 1'b0;
      since_r <= '0;
    end else begin
      ref_d_r <= ref_osc;
      if (ref_edge) begin
        since_r <= '0;
      end else if (!ref_stuck) begin
        since_r <= since_r + TO_W'(1);
      end
    end
  end

  // Window result is kept until the next window ends, so recovery is seen
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_r      <= '0;
      win_r      <= '0;
      mismatch_r <= 1'b0;
    end else if (ref_edge) begin
      if (win_r == WIN_W'(REF_WIN)) begin
        mismatch_r <= (per_r > PER_W'(HI_CYC)) || (per_r < PER_W'(LO_CYC));
        per_r      <= PER_W'(1);
        win_r      <= WIN_W'(1);
      end else begin
        per_r <= (win_r == '0) ? PER_W'(1) : per_r + PER_W'(1);
        win_r <= win_r + WIN_W'(1);
      end
    end else if (win_r != '0 && per_r != '1) begin
      per_r <= per_r + PER_W'(1);
    end
  end

  // ==========================================================
  // Fault flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_fault_flags_a <= SFA_RST;
    end else if (por_req) begin
      supply_fault_flags_a <= SFA_RST;
    end else begin
      supply_fault_flags_a <= supply_fault_flags_a & ~{FLAG_W{rd_flags_a}};
      supply_fault_flags_a[SFA_CP_UV] <= sticky(supply_fault_flags_a[SFA_CP_UV],
                                                rd_flags_a, cp_uv_f);
      supply_fault_flags_a[SFA_ANALOG_GROUND]  <= sticky(supply_fault_flags_a[SFA_ANALOG_GROUND],
                                                rd_flags_a, analog_ground_f);
      supply_fault_flags_a[SFA_DIGITAL_GROUND]  <= sticky(supply_fault_flags_a[SFA_DIGITAL_GROUND],
                                                rd_flags_a, digital_ground_f);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_selftest_flags_b <= SFB_RST;
    end else if (por_req) begin
      supply_selftest_flags_b <= SFB_RST;
      supply_selftest_flags_b[SFB_OD_FAIL] <= od_fail;
    end else begin
      supply_selftest_flags_b <= supply_selftest_flags_b & ~{FLAG_W{rd_flags_b}};
      supply_selftest_flags_b[SFB_REF_STUCK] <= sticky(
        supply_selftest_flags_b[SFB_REF_STUCK], rd_flags_b, ref_stuck);
      supply_selftest_flags_b[SFB_MAIN_OSC] <= sticky(
        supply_selftest_flags_b[SFB_MAIN_OSC], rd_flags_b, osc_fault);
      supply_selftest_flags_b[SFB_ANALOG_GROUND_ST] <= sticky(
        supply_selftest_flags_b[SFB_ANALOG_GROUND_ST], rd_flags_b,
        st_r == ST_PORTEST && st_nxt == ST_IDLE && !(seen_r[0] || analog_ground_loss));
      supply_selftest_flags_b[SFB_DIGITAL_GROUND_ST] <= sticky(
        supply_selftest_flags_b[SFB_DIGITAL_GROUND_ST], rd_flags_b,
        st_r == ST_PORTEST && st_nxt == ST_IDLE && !(seen_r[1] || digital_ground_loss));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_fault_flags_b <= {NCH{CHB_RST}};
    end else if (por_req) begin
      channel_fault_flags_b <= {NCH{CHB_RST}};
    end else begin
      for (int c = 0; c < NCH; c++) begin
        channel_fault_flags_b[c][CHB_GND_LOSS] <= sticky(
          channel_fault_flags_b[c][CHB_GND_LOSS], rd_chan_flags[c],
          chan_loss_f[c] || chan_fail[c]);
        channel_fault_flags_b[c][CHB_GND_BUSY] <=
          chan_busy_r[c] ? (chan_cnt_r[c] != TC_W'(ST_WAIT_CYC - 1)) : chan_test_start[c];
      end
    end
  end

  // ==========================================================
  // Driver enables; a present fault wins over a re-enable request
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      sol_en_nxt[c] = (sol_en_r[c] || sol_reenable[c]) && !global_off
                      && !chan_loss_f[c];
    end
    fs_en_nxt = (fs_en_r || fs_reenable) && !global_off;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sol_en_r     <= '0;
      fs_en_r      <= 1'b0;
      sol_en       <= '0;
      fs_predrv_en <= 1'b0;
      safety_off   <= 1'b1;
    end else begin
      sol_en_r     <= por_req ? '0 : sol_en_nxt;
      fs_en_r      <= por_req ? 1'b0 : fs_en_nxt;
      sol_en       <= por_req ? '0 : sol_en_nxt;
      fs_predrv_en <= !por_req && fs_en_nxt && !osc_fault;
      safety_off   <= por_req || osc_fault;
    end
  end

  // ==========================================================
  // Checks
  cp_uv_flag_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cp_uv_f && !por_req |=> supply_fault_flags_a[SFA_CP_UV] && sol_en == '0 && !fs_predrv_en
  ) else $error("charge-pump undervoltage not flagged or drivers left on");

  flag_clear_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_flags_a && !cp_uv_f && !por_req |=> !supply_fault_flags_a[SFA_CP_UV]
  ) else $error("supply flag survived a read without a fault");

  por_effect_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    por_req |=> supply_fault_flags_a[SFA_POR] && sol_en == '0 && !fs_predrv_en
                && gnd_test_inj
  ) else $error("reset event did not clear outputs or set its flag");

  od_busy_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    st_r == ST_IDLE && on_demand_test_control_start && !por_req |=>
      on_demand_test_control[ODT_RUN][*8]
  ) else $error("self-test status bit not held while testing");

  gnd_off_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (analog_ground_f || digital_ground_f) |=> sol_en == '0 && !fs_predrv_en
  ) else $error("ground loss left drivers enabled");

  chan_only_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    chan_loss_f[0] && !global_off && !por_req && fs_en_r && !osc_fault |=>
      !sol_en[0] && channel_fault_flags_b[0][CHB_GND_LOSS] && fs_predrv_en
  ) else $error("channel ground loss handled wrongly");

  osc_off_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    osc_fault |=> safety_off && !fs_predrv_en
  ) else $error("oscillator fault did not hold fail-safe off");

  ref_stuck_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(ref_stuck) |-> $past(since_r) == TO_W'(OSC_TIMEOUT_CYC - 1)
      ##1 supply_selftest_flags_b[SFB_REF_STUCK] || por_req
  ) else $error("reference stuck not declared at the timeout");

  mismatch_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ref_edge && win_r == WIN_W'(REF_WIN) && per_r > PER_W'(HI_CYC) |=> mismatch_r
  ) else $error("oscillator mismatch not flagged");

endmodule

/* rtl/filt_if.sv */
// Raw and filtered comparator levels between the monitor and its filters
`timescale 1ns/1ns
interface filt_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] filt;
  modport src (output raw, input filt);
  modport flt (input raw, output filt);
endinterface
